// file: hlfs_pkg.sv
// package of constants and carrier types for the host link failsafe supervisor
package hlfs_pkg;

  // ***************************************************************
  // timing figures and derived cycle counts
  // ***************************************************************
  localparam int CLK_HZ = 50000000;
  localparam int WD_SHORT_MS = 32;
  localparam int WD_LONG_MS = 128;
  localparam int IN_DGL_US = 200;
  localparam int RST_DGL_US = 10;
  localparam int REF_DGL_NS = 2000;
  localparam int CLK_LOW_HZ = 100;
  localparam int WD_SHORT_CYC = CLK_HZ / 1000 * WD_SHORT_MS;
  localparam int WD_LONG_CYC = CLK_HZ / 1000 * WD_LONG_MS;
  localparam int IN_DGL_CYC = (CLK_HZ / 1000000) * IN_DGL_US;
  localparam int RST_DGL_CYC = (CLK_HZ / 1000000) * RST_DGL_US;
  localparam int REF_DGL_CYC = (CLK_HZ / 1000000) * REF_DGL_NS / 1000;
  localparam int CLK_LOW_CYC = CLK_HZ / CLK_LOW_HZ;
  localparam int FRAME_BITS = 16;
  localparam int NCH = 4;
  localparam int CNT_W = 24;
  localparam int BIT_W = 4;

  // operating modes
  typedef enum logic [1:0] {
    HLFS_SLEEP = 2'h0,
    HLFS_NORMAL = 2'h1,
    HLFS_FAIL = 2'h3
  } hlfs_mode_t;

  // status carried back toward the serial reporting path
  typedef struct packed {
    logic link_failure_flag;
    logic failsafe_pin_state_bit;
    logic clock_fail;
  } hlfs_status_t;

  // serial link pins, raw from the package
  typedef struct packed {
    logic sclk;
    logic csn;
    logic sdi;
  } hlfs_link_t;

endpackage

// file: hlfs_supervisor.sv
// host link failsafe supervisor: watchdog, deglitchers, clock monitor
`timescale 1ns/1ns

// What this block does
// - any link fault forces fail mode
// - frame without inverted toggle bit versus previous frame is a fault
// - no valid frame within 32 ms or 128 ms timeout is a fault
// - clock bits per chip select zero or not multiple of sixteen is a fault
// - stuck serial input or dead supply caught through the toggle check
// - fault sets link failure flag, reported in the next transfer
// - link failure flag held while in fail mode
// - link failure flag cleared on fail to normal transition
// - fail-force and direct inputs deglitched 200 us both edges
// - filtered fail-force high forces fail mode
// - filtered direct input drives its matching channel in fail mode
// - reset pin deglitched 10 us on falling edge only
// - reference clock deglitched 2 us; too fast counts as failure
// - clock monitoring starts at reset pin release
// - slow clock in normal mode: outputs follow channel requests, else configured duty
// - clock-fail clears only when fault gone, then quick status read
// - external driver output follows channel six only in normal mode
// - external driver output low in sleep and fail mode
// - in fail mode channels follow their direct inputs
// - fail-force pin level readable as status bit
module hlfs_supervisor (
  input wire logic clock,
  input wire logic rstn,
  input wire hlfs_pkg::hlfs_link_t link,
  input wire logic frame_toggle_bit,
  input wire logic watchdog_period_select,
  input wire logic failsafe_force_input,
  input wire logic [3:0] direct_channel_inputs,
  input wire logic active_low_reset_pin,
  input wire logic ref_clock,
  input wire logic sleep_request,
  input wire logic [3:0] channel_on_request,
  input wire logic [3:0] pwm_channel,
  input wire logic channel_six_setting,
  input wire logic quick_status_read,
  output hlfs_pkg::hlfs_mode_t mode,
  output hlfs_pkg::hlfs_status_t status,
  output logic [3:0] channel_out,
  output logic external_driver_control_output,
  output logic link_fault_pulse
);

  // ***************************************************************
  // helpers
  // ***************************************************************
  // symmetric deglitch step: count while raw differs, flip at the limit
  function automatic logic [hlfs_pkg::CNT_W:0] dgl_step(
    input logic raw, input logic filt,
    input logic [hlfs_pkg::CNT_W-1:0] cnt,
    input logic [hlfs_pkg::CNT_W-1:0] lim);
    logic [hlfs_pkg::CNT_W:0] r;
    r = {filt, hlfs_pkg::CNT_W'(0)};
    if (raw != filt) begin
      if (cnt >= lim - hlfs_pkg::CNT_W'(1)) begin
        r = {raw, hlfs_pkg::CNT_W'(0)};
      end else begin
        r = {filt, cnt + hlfs_pkg::CNT_W'(1)};
      end
    end
    return r;
  endfunction

  localparam logic [hlfs_pkg::CNT_W-1:0] IN_LIM =
    hlfs_pkg::CNT_W'(hlfs_pkg::IN_DGL_CYC);
  localparam logic [hlfs_pkg::CNT_W-1:0] RST_LIM =
    hlfs_pkg::CNT_W'(hlfs_pkg::RST_DGL_CYC);
  localparam logic [hlfs_pkg::CNT_W-1:0] REF_LIM =
    hlfs_pkg::CNT_W'(hlfs_pkg::REF_DGL_CYC);
  localparam logic [hlfs_pkg::CNT_W-1:0] SLOW_LIM =
    hlfs_pkg::CNT_W'(hlfs_pkg::CLK_LOW_CYC);

  // ***************************************************************
  // input synchronisers (two flops each, first flop read by nobody else)
  // ***************************************************************
  logic [8:0] sync_a;
  logic [8:0] sync_b;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sync_a <= 9'h180; // pins at idle: reset released, deselected
      sync_b <= 9'h180;
    end else begin
      sync_a <= {active_low_reset_pin, link.csn, ref_clock,
                 link.sclk, link.sdi, failsafe_force_input,
                 direct_channel_inputs[3:1]};
      sync_b <= sync_a;
    end
  end
  // bit order in sync_b: 8 rst pin, 7 csn, 6 ref, 5 sclk, 4 sdi (unused
  // here), 3 force, 2:0 direct[3:1]; direct[0] kept separately below
  logic din0_a;
  logic din0_b;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      din0_a <= 1'b0;
      din0_b <= 1'b0;
    end else begin
      din0_a <= direct_channel_inputs[0];
      din0_b <= din0_a;
    end
  end
  logic rst_pin_s;
  logic csn_s;
  logic ref_s;
  logic sclk_s;
  logic force_s;
  logic [3:0] din_s;
  assign rst_pin_s = sync_b[8];
  assign csn_s = sync_b[7];
  assign ref_s = sync_b[6];
  assign sclk_s = sync_b[5];
  assign force_s = sync_b[3];
  assign din_s = {sync_b[2:0], din0_b};

  // ***************************************************************
  // deglitch filters
  // ***************************************************************
  logic [4:0] filt;
  logic [hlfs_pkg::CNT_W-1:0] fcnt [5];
  logic [4:0] raw5;
  assign raw5 = {force_s, din_s};
  // five identical counters; fail-force is bit 4
  always_ff @(posedge clock) begin
    if (!rstn) begin
      filt <= 5'h00;
      for (int i = 0; i < 5; i++) begin
        fcnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        {filt[i], fcnt[i]} <= dgl_step(raw5[i], filt[i], fcnt[i],
                                       IN_LIM);
      end
    end
  end
  logic filtered_failsafe_request;
  logic [3:0] filtered_direct_input;
  assign filtered_failsafe_request = filt[4];
  assign filtered_direct_input = filt[3:0];

  // reset pin: falling edge filtered, rising edge immediate
  logic rst_filt;
  logic [hlfs_pkg::CNT_W-1:0] rcnt;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rst_filt <= 1'b1;
      rcnt <= '0;
    end else if (rst_pin_s) begin
      rst_filt <= 1'b1;
      rcnt <= '0;
    end else begin
      {rst_filt, rcnt} <= dgl_step(1'b0, rst_filt, rcnt, RST_LIM);
    end
  end

  // reference clock filter
  logic ref_filt;
  logic ref_filt_q;
  logic [hlfs_pkg::CNT_W-1:0] kcnt;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ref_filt <= 1'b0;
      ref_filt_q <= 1'b0;
      kcnt <= '0;
    end else begin
      {ref_filt, kcnt} <= dgl_step(ref_s, ref_filt, kcnt, REF_LIM);
      ref_filt_q <= ref_filt;
    end
  end

  // ***************************************************************
  // clock-fail monitor: no filtered rising edge within the slow limit
  // ***************************************************************
  logic [hlfs_pkg::CNT_W-1:0] scnt;
  logic clk_fault;
  logic clock_fail;
  always_ff @(posedge clock) begin
    if (!rstn || !rst_filt) begin
      scnt <= '0;
      clk_fault <= 1'b0;
    end else if (ref_filt && !ref_filt_q) begin
      scnt <= '0;
      clk_fault <= 1'b0;
    end else if (scnt >= SLOW_LIM - hlfs_pkg::CNT_W'(1)) begin
      clk_fault <= 1'b1;
    end else begin
      scnt <= scnt + hlfs_pkg::CNT_W'(1);
    end
  end
  // latched diagnosis; a new fault wins over the read clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      clock_fail <= 1'b0;
    end else if (clk_fault) begin
      clock_fail <= 1'b1;
    end else if (quick_status_read) begin
      clock_fail <= 1'b0;
    end
  end

  // ***************************************************************
  // frame checker and watchdog
  // ***************************************************************
  logic csn_q;
  logic sclk_q;
  logic [hlfs_pkg::BIT_W-1:0] bitcnt;
  logic bits_seen;
  logic prev_toggle;
  logic [hlfs_pkg::CNT_W-1:0] wdcnt;
  logic frame_end;
  logic len_bad;
  logic tog_bad;
  logic wd_expired;
  assign frame_end = csn_s && !csn_q;
  assign len_bad = frame_end && (bitcnt != '0 || !bits_seen);
  assign tog_bad = frame_end && frame_toggle_bit == prev_toggle;
  assign wd_expired = wdcnt == '0;
  assign link_fault_pulse = len_bad || tog_bad || wd_expired;

  // bit counter while chip select is low, modulo sixteen
  always_ff @(posedge clock) begin
    if (!rstn) begin
      csn_q <= 1'b1;
      sclk_q <= 1'b0;
      bitcnt <= '0;
      bits_seen <= 1'b0;
    end else begin
      csn_q <= csn_s;
      sclk_q <= sclk_s;
      if (csn_s) begin
        bitcnt <= '0;
        bits_seen <= 1'b0;
      end else if (sclk_s && !sclk_q) begin
        bitcnt <= bitcnt + hlfs_pkg::BIT_W'(1);
        bits_seen <= 1'b1;
      end
    end
  end

  // watchdog reload on a good frame or on expiry, else count down
  always_ff @(posedge clock) begin
    if (!rstn) begin
      prev_toggle <= 1'b0;
      wdcnt <= hlfs_pkg::CNT_W'(hlfs_pkg::WD_SHORT_CYC);
    end else begin
      if (frame_end) begin
        prev_toggle <= frame_toggle_bit;
      end
      if ((frame_end && !len_bad && !tog_bad) || wd_expired) begin
        wdcnt <= watchdog_period_select ?
          hlfs_pkg::CNT_W'(hlfs_pkg::WD_LONG_CYC) :
          hlfs_pkg::CNT_W'(hlfs_pkg::WD_SHORT_CYC);
      end else begin
        wdcnt <= wdcnt - hlfs_pkg::CNT_W'(1);
      end
    end
  end

  // ***************************************************************
  // mode control and link failure flag
  // ***************************************************************
  logic link_failure_flag;
  logic link_fail_latched;
  always_ff @(posedge clock) begin
    if (!rstn || !rst_filt) begin
      link_fail_latched <= 1'b0;
    end else if (link_fault_pulse) begin
      link_fail_latched <= 1'b1;
    end else if (mode == hlfs_pkg::HLFS_FAIL && !filtered_failsafe_request
                 && frame_end) begin
      link_fail_latched <= 1'b0; // good frame lets the device recover
    end
  end
  // any live cause keeps fail mode; shared with the flag clear below
  logic fail_hold;
  assign fail_hold = filtered_failsafe_request || link_fault_pulse
    || link_fail_latched;
  always_ff @(posedge clock) begin
    if (!rstn || !rst_filt) begin
      mode <= hlfs_pkg::HLFS_NORMAL;
    end else if (fail_hold) begin
      mode <= hlfs_pkg::HLFS_FAIL;
    end else if (sleep_request) begin
      mode <= hlfs_pkg::HLFS_SLEEP;
    end else begin
      mode <= hlfs_pkg::HLFS_NORMAL;
    end
  end
  // flag: fault sets (wins), kept through fail, cleared leaving fail for normal
  always_ff @(posedge clock) begin
    if (!rstn || !rst_filt) begin
      link_failure_flag <= 1'b0;
    end else if (link_fault_pulse) begin
      link_failure_flag <= 1'b1;
    end else if (mode == hlfs_pkg::HLFS_FAIL && !fail_hold
                 && !sleep_request) begin
      link_failure_flag <= 1'b0; // cleared on the edge mode leaves
    end else if (mode == hlfs_pkg::HLFS_FAIL) begin
      link_failure_flag <= link_failure_flag;
    end else if (mode == hlfs_pkg::HLFS_NORMAL) begin
      link_failure_flag <= 1'b0;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  always_ff @(posedge clock) begin
    if (!rstn) begin
      status <= '0;
      channel_out <= 4'h0;
      external_driver_control_output <= 1'b0;
    end else begin
      status <= '{link_failure_flag, force_s, clock_fail};
      if (mode == hlfs_pkg::HLFS_FAIL) begin
        channel_out <= filtered_direct_input;
      end else if (mode == hlfs_pkg::HLFS_SLEEP) begin
        channel_out <= 4'h0;
      end else if (clk_fault) begin
        channel_out <= channel_on_request;
      end else begin
        channel_out <= pwm_channel;
      end
      external_driver_control_output <= mode == hlfs_pkg::HLFS_NORMAL
        && channel_six_setting;
    end
  end

endmodule

// file: hlfs_supervisor_sva.sv
// assertion checker on the ports of the host link failsafe supervisor
`timescale 1ns/1ns
module hlfs_supervisor_sva (
  input wire logic clock,
  input wire logic rstn,
  input wire logic channel_six_setting,
  input wire logic quick_status_read,
  input wire hlfs_pkg::hlfs_mode_t mode,
  input wire hlfs_pkg::hlfs_status_t status,
  input wire logic external_driver_control_output,
  input wire logic link_fault_pulse
);
  // ************************************************
  // mode, flag, driver output and clock-fail relations
  // ************************************************
  // one clock domain, so clock and reset are given once
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // a link fault must land in fail mode at the next edge
  fault_fail_a: assert property (link_fault_pulse |=>
    mode == hlfs_pkg::HLFS_FAIL) else $error("fault kept mode");
  flag_set_a: assert property (link_fault_pulse |->
    ##[1:2] status.link_failure_flag) else $error("flag not set");
  pulse_one_a: assert property (link_fault_pulse |=>
    !link_fault_pulse) else $error("fault pulse too long");
  flag_hold_a: assert property ($fell(status.link_failure_flag) |->
    mode != hlfs_pkg::HLFS_FAIL) else $error("flag lost in fail");
  flag_clear_a: assert property (($past(mode) == hlfs_pkg::HLFS_FAIL &&
    mode == hlfs_pkg::HLFS_NORMAL) |-> ##[0:1] !status.link_failure_flag)
    else $error("flag kept on return");
  // two-cycle antecedents allow the output register one edge of lag
  ext_off_a: assert property ((mode != hlfs_pkg::HLFS_NORMAL) [*2] |->
    !external_driver_control_output) else $error("ext on outside normal");
  ext_on_a: assert property ((mode == hlfs_pkg::HLFS_NORMAL &&
    channel_six_setting) [*2] |-> external_driver_control_output)
    else $error("ext off in normal");
  ext_idle_a: assert property (!channel_six_setting [*2] |->
    !external_driver_control_output) else $error("ext on unrequested");
  // the read clears the latch, the status register shows it one edge later
  clk_clear_a: assert property ($fell(status.clock_fail) |->
    $past(quick_status_read, 2)) else $error("clock fail cleared unread");
endmodule

bind hlfs_supervisor hlfs_supervisor_sva i_sva (
  .clock(clock), .rstn(rstn), .channel_six_setting(channel_six_setting),
  .quick_status_read(quick_status_read), .mode(mode), .status(status),
  .external_driver_control_output(external_driver_control_output),
  .link_fault_pulse(link_fault_pulse)
);

// file: hlfs_host_model.sv
// host model: serial frames that carry the watchdog toggle bit
`timescale 1ns/1ns
module hlfs_host_model (
  input wire logic clock,
  output hlfs_pkg::hlfs_link_t link,
  output logic frame_toggle_bit
);
  // ************************************************
  // frame driver
  // ************************************************
  // idle: deselected, serial clock parked low
  initial begin
    link = 3'h2;
    frame_toggle_bit = 1'h0;
  end

  // n clock bits under one select, 8 system cycles a bit (160 ns)
  task frame(input int n, input logic t);
    int i;
    @(posedge clock);
    link.csn <= 1'h0;
    frame_toggle_bit <= t;
    for (i = 0; i < n; i++) begin
      repeat (4) @(posedge clock);
      link.sclk <= 1'h1;
      repeat (4) @(posedge clock);
      link.sclk <= 1'h0;
      link.sdi <= ~link.sdi;
    end
    repeat (4) @(posedge clock);
    link.csn <= 1'h1;
    link.sdi <= ~link.sdi; // released line never shows a held value
    repeat (12) @(posedge clock); // covers sync and frame-end latency
  endtask
endmodule

// file: tb_hlfs_supervisor.sv
// self-checking bench for the host link failsafe supervisor
`timescale 1ns/1ns
module tb_hlfs_supervisor;
  // ************************************************
  // signals and instances
  // ************************************************
  logic clock = 1'h0, rstn = 1'h0, fs = 1'h0, rp = 1'h1, slp = 1'h0;
  logic six = 1'h0, qsr = 1'h0, refc = 1'h0, sel = 1'h0, tgl, ext, flt;
  logic [3:0] din = 4'h0, creq = 4'h0, pwm = 4'h0, chan;
  hlfs_pkg::hlfs_link_t link;
  hlfs_pkg::hlfs_mode_t mode;
  hlfs_pkg::hlfs_status_t st;
  int n_errors = 0, cmp_count = 0, cyc = 0, n_fault = 0;

  hlfs_supervisor i_dut (
    .clock(clock), .rstn(rstn), .link(link), .frame_toggle_bit(tgl),
    .watchdog_period_select(sel), .failsafe_force_input(fs),
    .direct_channel_inputs(din), .active_low_reset_pin(rp),
    .ref_clock(refc), .sleep_request(slp), .channel_on_request(creq),
    .pwm_channel(pwm), .channel_six_setting(six), .quick_status_read(qsr),
    .mode(mode), .status(st), .channel_out(chan),
    .external_driver_control_output(ext), .link_fault_pulse(flt)
  );
  hlfs_host_model i_host (.clock(clock), .link(link), .frame_toggle_bit(tgl));

  always #10 clock = ~clock;

  // cycle count, fault tally and hang guard
  always @(posedge clock) begin
    cyc++;
    if (flt === 1'h1) n_fault++;
    if (cyc == 60000) begin
      n_errors++;
      print_verdict();
    end
  end

  task cy(input int n);
    repeat (n) @(posedge clock);
  endtask

  // compare at the falling edge, when registers have settled
  task chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    @(negedge clock);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task print_verdict;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  // warm-up frames settle the toggle history whatever its reset value
  initial begin
    cy(2);
    rstn <= 1'h1;
    i_host.frame(16, 1'h1);
    i_host.frame(16, 1'h0);
    i_host.frame(32, 1'h1);
    n_fault = 0;
    six <= 1'h1;
    pwm <= 4'hA;
    cy(4);
    chk("ext", ext, 4'h1);
    chk("mode", mode, 4'h1);
    chk("chan", chan, 4'hA);
    chk("clkfail", st.clock_fail, 4'h0);
    cy(1);
    slp <= 1'h1;
    cy(4);
    chk("sleep", mode, 4'h0);
    chk("ext", ext, 4'h0);
    cy(1);
    slp <= 1'h0;
    cy(4);
    i_host.frame(15, 1'h0);
    chk("mode", mode, 4'h3);
    chk("flag", st.link_failure_flag, 4'h1);
    chk("ext", ext, 4'h0);
    i_host.frame(17, 1'h1);
    din <= 4'hF;
    cy(10010);
    chk("flag", st.link_failure_flag, 4'h1);
    chk("chan", chan, 4'hF);
    cy(1);
    din <= 4'h0;
    cy(10010);
    chk("chan", chan, 4'h0);
    i_host.frame(16, 1'h0);
    chk("mode", mode, 4'h1);
    chk("flag", st.link_failure_flag, 4'h0);
    chk("faults", n_fault[3:0], 4'h2);
    i_host.frame(16, 1'h0);
    chk("mode", mode, 4'h3);
    // a short low pulse on the reset pin must be filtered out
    cy(1);
    rp <= 1'h0;
    cy(100);
    rp <= 1'h1;
    cy(10);
    chk("mode", mode, 4'h3);
    cy(1);
    rp <= 1'h0;
    cy(520);
    rp <= 1'h1;
    cy(5);
    chk("mode", mode, 4'h1);
    chk("flag", st.link_failure_flag, 4'h0);
    cy(1);
    fs <= 1'h1;
    cy(9900);
    chk("mode", mode, 4'h1);
    cy(200);
    chk("mode", mode, 4'h3);
    chk("pin", st.failsafe_pin_state_bit, 4'h1);
    cy(1);
    fs <= 1'h0;
    cy(5);
    chk("pin", st.failsafe_pin_state_bit, 4'h0);
    print_verdict();
  end
endmodule
